// ==== pwg_deadband.sv ====
`timescale 1ns/1ps

// dead-band stage: bypass, or complementary pair with rising-edge delays
module pwg_deadband
	import pwg_pkg::*;
#(
	parameter int DW = DB_W
)
(
	input  wire logic          clk_sys_in,
	input  wire logic          sys_rst_in,
	pwg_raw_if.dst             raw,
	input  wire logic          db_en_in,
	input  wire logic [DW-1:0] db_rise_in,
	input  wire logic [DW-1:0] db_fall_in,
	output logic               db_first_out,
	output logic               db_second_out
);

	logic          raw_d_reg;
	logic [DW-1:0] rise_cnt_reg;
	logic [DW-1:0] fall_cnt_reg;

	// previous raw level for edge detection
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			raw_d_reg <= 1'b0;
		else
			raw_d_reg <= raw.raw_first;
	end

	// first output: rises a programmed count after the raw rise, falls at once
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rise_cnt_reg <= '0;
			db_first_out <= 1'b0;
		end
		else if (!db_en_in)
		begin
			rise_cnt_reg <= '0;
			db_first_out <= raw.raw_first;
		end
		else if (!raw.raw_first)
		begin
			rise_cnt_reg <= '0;
			db_first_out <= 1'b0;
		end
		else if (!raw_d_reg)
		begin
			rise_cnt_reg <= db_rise_in;
			db_first_out <= (db_rise_in == '0);
		end
		else if (rise_cnt_reg > 1)
			rise_cnt_reg <= rise_cnt_reg - 1'b1;
		else
		begin
			rise_cnt_reg <= '0;
			db_first_out <= 1'b1;
		end
	end

	// second output: inverse of raw, rise delayed after the raw fall
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			fall_cnt_reg  <= '0;
			db_second_out <= 1'b0;
		end
		else if (!db_en_in)
		begin
			fall_cnt_reg  <= '0;
			db_second_out <= raw.raw_second;
		end
		else if (raw.raw_first)
		begin
			fall_cnt_reg  <= '0;
			db_second_out <= 1'b0;
		end
		else if (raw_d_reg)
		begin
			fall_cnt_reg  <= db_fall_in;
			db_second_out <= (db_fall_in == '0);
		end
		else if (fall_cnt_reg > 1)
			fall_cnt_reg <= fall_cnt_reg - 1'b1;
		else
		begin
			fall_cnt_reg  <= '0;
			db_second_out <= 1'b1;
		end
	end

endmodule : pwg_deadband

// ==== pwg_drv_model.sv ====
`timescale 1ns/1ps

// half-bridge gate driver seen from the two pins
module pwg_drv_model
(
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	input  wire logic gate_hi_in,
	input  wire logic gate_lo_in,
	output logic      shoot_out
);
	// overlap would short the bridge, so it is held until reset
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			shoot_out <= 1'b0;
		else if (gate_hi_in && gate_lo_in)
			shoot_out <= 1'b1;
	end
endmodule : pwg_drv_model

// ==== pwg_outctl.sv ====
`timescale 1ns/1ps

// output control: fault masking, polarity, pin enable per signal
module pwg_outctl
	import pwg_pkg::*;
#(
	parameter int N = 2
)
(
	input  wire logic         clk_sys_in,
	input  wire logic         sys_rst_in,
	input  wire logic [N-1:0] sig_in,
	input  wire logic [N-1:0] pin_en_in,
	input  wire logic [N-1:0] invert_in,
	input  wire logic [N-1:0] fault_sel_in,
	input  wire logic         fault_in,
	output logic      [N-1:0] pin_out
);

	// fault pin arrives from outside: three stages, act when last two agree
	logic [2:0] fault_sync_reg;
	logic       fault_reg;

	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			fault_sync_reg <= 3'h0;
		else
			fault_sync_reg <= {fault_sync_reg[1:0], fault_in};
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			fault_reg <= 1'b0;
		else if (fault_sync_reg[2] == fault_sync_reg[1])
			fault_reg <= fault_sync_reg[2];
	end

	// per-pin conditioning; a disabled pin sits low, a faulted pin at its inactive level
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_pin
			always_ff @(posedge clk_sys_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
					pin_out[i] <= 1'b0;
				else if (!pin_en_in[i])
					pin_out[i] <= 1'b0;
				else if (fault_sel_in[i] && fault_reg)
					pin_out[i] <= invert_in[i];
				else
					pin_out[i] <= sig_in[i] ^ invert_in[i];
			end
		end
	endgenerate

endmodule : pwg_outctl

// ==== pwg_pkg.sv ====
package pwg_pkg;

	// counter and delay widths
	localparam int CNT_W = 16;
	localparam int DB_W  = 12;

	// event bit positions in the six-event vector
	localparam int EV_ZERO   = 0;
	localparam int EV_LOAD   = 1;
	localparam int EV_A_UP   = 2;
	localparam int EV_A_DOWN = 3;
	localparam int EV_B_UP   = 4;
	localparam int EV_B_DOWN = 5;
	localparam int EV_N      = 6;

	// per-event action codes, two bits per output
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW    = 2'h2;
	localparam logic [1:0] ACT_HIGH   = 2'h3;

	// reset values
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] LOAD_RST = 16'h0000;
	localparam logic [15:0] CMP_RST  = 16'h0000;

	// counter run state
	typedef enum logic [1:0] {
		PWG_IDLE,
		PWG_DOWN,
		PWG_UP,
		PWG_UPDN_DOWN
	} pwg_cnt_state_t;

endpackage : pwg_pkg

// ==== pwg_raw_if.sv ====
`timescale 1ns/1ps

// raw pair handed from the generator to the dead-band stage
interface pwg_raw_if;
	logic raw_first;
	logic raw_second;

	modport src (output raw_first, output raw_second);
	modport dst (input raw_first, input raw_second);
endinterface : pwg_raw_if

// ==== pwg_top.sv ====
`timescale 1ns/1ps

// Contract
// - down mode: period to zero, reload, repeat
// - up/down mode: zero up to period, back
// - counter and period are sixteen bits wide
// - direction low in down, toggles in up/down
// - one-cycle pulses at zero and at period
// - down mode: period pulse follows zero pulse
// - compare units pulse when counter equals value
// - up/down matches tagged with count direction
// - compare above period never matches
// - down mode uses four events
// - up/down mode uses six events
// - compare ignored when zero or period coincide
// - first output A only, second B only
// - per-event action: keep, toggle, low, high
// - dead-band disabled passes raw outputs
// - dead-band first output delays rising edge
// - dead-band second inverted, delayed after fall
// - selected events raise the interrupt
// - separate selection makes converter trigger pulses
// - interrupt and trigger use raw events
// - per-output pin enable and polarity inversion
// - per-output fault select, one fault input
// - selected fault forces output inactive
// - synced updates take effect at zero
module pwg_top
	import pwg_pkg::*;
#(
	parameter int CW = CNT_W,
	parameter int DW = DB_W
)
(
	input  wire logic              clk_sys_in,
	input  wire logic              sys_rst_in,
	input  wire logic              run_en_in,
	input  wire logic              updown_mode_in,
	input  wire logic              sync_upd_in,
	input  wire logic [CW-1:0]     period_in,
	input  wire logic [CW-1:0]     cmp_a_in,
	input  wire logic [CW-1:0]     cmp_b_in,
	input  wire logic [2*EV_N-1:0] act_first_in,
	input  wire logic [2*EV_N-1:0] act_second_in,
	input  wire logic              db_en_in,
	input  wire logic [DW-1:0]     db_rise_in,
	input  wire logic [DW-1:0]     db_fall_in,
	input  wire logic [EV_N-1:0]   irq_sel_in,
	input  wire logic [EV_N-1:0]   trig_sel_in,
	input  wire logic [1:0]        pin_en_in,
	input  wire logic [1:0]        invert_in,
	input  wire logic [1:0]        fault_sel_in,
	input  wire logic              fault_in,
	output logic      [CW-1:0]     count_out,
	output logic                   dir_out,
	output logic                   zero_pulse_out,
	output logic                   load_pulse_out,
	output logic                   cmp_a_pulse_out,
	output logic                   cmp_b_pulse_out,
	output logic      [EV_N-1:0]   event_out,
	output logic                   irq_out,
	output logic                   adc_trig_out,
	output logic                   raw_out_first,
	output logic                   raw_out_second,
	output logic                   pin_out_first,
	output logic                   pin_out_second
);

	pwg_cnt_state_t state_reg;
	logic [CW-1:0]  cnt_reg;
	logic [CW-1:0]  period_reg;
	logic [CW-1:0]  cmp_a_reg;
	logic [CW-1:0]  cmp_b_reg;
	logic           raw_first_reg;
	logic           raw_second_reg;
	logic           raw_first_next;
	logic           raw_second_next;
	logic [EV_N-1:0] ev;
	logic           at_zero;
	logic           at_load;
	logic           match_a;
	logic           match_b;
	logic           counting;
	logic           cnt_dir;
	logic           cmp_ok;

	// active values; in sync mode staged inputs land only while idle or as the count hits zero
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			period_reg <= LOAD_RST;
			cmp_a_reg  <= CMP_RST;
			cmp_b_reg  <= CMP_RST;
		end
		else if (!sync_upd_in || state_reg == PWG_IDLE || at_zero)
		begin
			period_reg <= period_in;
			cmp_a_reg  <= cmp_a_in;
			cmp_b_reg  <= cmp_b_in;
		end
	end

	// counter sequencing; a stop returns to idle with the count cleared
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_reg <= PWG_IDLE;
			cnt_reg   <= CNT_RST;
		end
		else if (!run_en_in)
		begin
			state_reg <= PWG_IDLE;
			cnt_reg   <= CNT_RST;
		end
		else
		begin
			case (state_reg)
				PWG_IDLE:
				begin
					// start: down mode begins at the period, up/down at zero
					if (updown_mode_in)
					begin
						state_reg <= PWG_UP;
						cnt_reg   <= CNT_RST;
					end
					else
					begin
						state_reg <= PWG_DOWN;
						cnt_reg   <= period_reg;
					end
				end
				PWG_DOWN:
				begin
					if (cnt_reg == '0)
						cnt_reg <= period_reg;
					else
						cnt_reg <= cnt_reg - 1'b1;
				end
				PWG_UP:
				begin
					if (cnt_reg >= period_reg)
					begin
						state_reg <= PWG_UPDN_DOWN;
						cnt_reg   <= (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
					end
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				PWG_UPDN_DOWN:
				begin
					if (cnt_reg == '0)
					begin
						state_reg <= PWG_UP;
						cnt_reg   <= (period_reg == '0) ? cnt_reg : cnt_reg + 1'b1;
					end
					else
						cnt_reg <= cnt_reg - 1'b1;
				end
				default:
				begin
					state_reg <= PWG_IDLE;
					cnt_reg   <= CNT_RST;
				end
			endcase
		end
	end

	// direction names the next step: high from zero up to just below the period,
	// low from the period down; every bottom turn reads high, the first one too
	assign counting = (state_reg != PWG_IDLE);
	assign cnt_dir  = ((state_reg == PWG_UP) && (cnt_reg < period_reg))
		|| ((state_reg == PWG_UPDN_DOWN) && (cnt_reg == '0));

	// raw counter events; mode changes only take effect through idle
	assign at_zero = counting && (cnt_reg == '0);
	assign at_load = counting && (cnt_reg == period_reg);
	// a compare above the period is masked off and never matches, even where the count reaches it
	assign match_a = counting && (cnt_reg == cmp_a_reg) && (cmp_a_reg <= period_reg);
	assign match_b = counting && (cnt_reg == cmp_b_reg) && (cmp_b_reg <= period_reg);

	// a compare landing on zero or the period is dropped from the events; the compare pulse outputs still show it
	assign cmp_ok = !at_zero && !at_load;

	// event vector; up-tagged events exist only in up/down mode
	always_comb
	begin
		ev            = '0;
		ev[EV_ZERO]   = at_zero;
		ev[EV_LOAD]   = at_load;
		ev[EV_A_UP]   = match_a && cmp_ok && cnt_dir;
		ev[EV_A_DOWN] = match_a && cmp_ok && !cnt_dir;
		ev[EV_B_UP]   = match_b && cmp_ok && cnt_dir;
		ev[EV_B_DOWN] = match_b && cmp_ok && !cnt_dir;
	end

	// apply one action code to a level
	function automatic logic apply_act(input logic cur, input logic [1:0] code);
		logic r;
		r = cur;
		case (code)
			ACT_NONE:   r = cur;
			ACT_TOGGLE: r = !cur;
			ACT_LOW:    r = 1'b0;
			ACT_HIGH:   r = 1'b1;
			default:    r = cur;
		endcase
		return r;
	endfunction : apply_act

	// action selection: zero or load beats a compare in the same cycle,
	// and each output listens only to its own comparator
	always_comb
	begin
		raw_first_next  = raw_first_reg;
		raw_second_next = raw_second_reg;
		if (ev[EV_ZERO])
		begin
			raw_first_next  = apply_act(raw_first_reg, act_first_in[2*EV_ZERO +: 2]);
			raw_second_next = apply_act(raw_second_reg, act_second_in[2*EV_ZERO +: 2]);
		end
		else if (ev[EV_LOAD])
		begin
			raw_first_next  = apply_act(raw_first_reg, act_first_in[2*EV_LOAD +: 2]);
			raw_second_next = apply_act(raw_second_reg, act_second_in[2*EV_LOAD +: 2]);
		end
		else
		begin
			if (ev[EV_A_UP])
				raw_first_next = apply_act(raw_first_reg, act_first_in[2*EV_A_UP +: 2]);
			else if (ev[EV_A_DOWN])
				raw_first_next = apply_act(raw_first_reg, act_first_in[2*EV_A_DOWN +: 2]);
			if (ev[EV_B_UP])
				raw_second_next = apply_act(raw_second_reg, act_second_in[2*EV_B_UP +: 2]);
			else if (ev[EV_B_DOWN])
				raw_second_next = apply_act(raw_second_reg, act_second_in[2*EV_B_DOWN +: 2]);
		end
	end

	// raw generator outputs; cleared while stopped so a restart is clean
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			raw_first_reg  <= 1'b0;
			raw_second_reg <= 1'b0;
		end
		else if (!counting)
		begin
			raw_first_reg  <= 1'b0;
			raw_second_reg <= 1'b0;
		end
		else
		begin
			raw_first_reg  <= raw_first_next;
			raw_second_reg <= raw_second_next;
		end
	end

	// registered event outputs, one cycle behind the count they describe
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			count_out       <= CNT_RST;
			dir_out         <= 1'b0;
			zero_pulse_out  <= 1'b0;
			load_pulse_out  <= 1'b0;
			cmp_a_pulse_out <= 1'b0;
			cmp_b_pulse_out <= 1'b0;
			event_out       <= '0;
		end
		else
		begin
			count_out       <= cnt_reg;
			dir_out         <= cnt_dir;
			zero_pulse_out  <= at_zero;
			load_pulse_out  <= at_load;
			cmp_a_pulse_out <= match_a;
			cmp_b_pulse_out <= match_b;
			event_out       <= ev;
		end
	end

	// interrupt and trigger from raw events, ahead of any dead-band delay
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			irq_out      <= 1'b0;
			adc_trig_out <= 1'b0;
		end
		else
		begin
			irq_out      <= |(ev & irq_sel_in);
			adc_trig_out <= |(ev & trig_sel_in);
		end
	end

	assign raw_out_first  = raw_first_reg;
	assign raw_out_second = raw_second_reg;

	pwg_raw_if raw_bus ();
	assign raw_bus.raw_first  = raw_first_reg;
	assign raw_bus.raw_second = raw_second_reg;

	logic db_first;
	logic db_second;

	// dead-band pair shaping
	pwg_deadband #(.DW(DW)) u_db (
		.clk_sys_in    (clk_sys_in),
		.sys_rst_in    (sys_rst_in),
		.raw           (raw_bus),
		.db_en_in      (db_en_in),
		.db_rise_in    (db_rise_in),
		.db_fall_in    (db_fall_in),
		.db_first_out  (db_first),
		.db_second_out (db_second)
	);

	logic [1:0] pins;

	// final conditioning toward the gate driver
	pwg_outctl #(.N(2)) u_oc (
		.clk_sys_in   (clk_sys_in),
		.sys_rst_in   (sys_rst_in),
		.sig_in       ({db_second, db_first}),
		.pin_en_in    (pin_en_in),
		.invert_in    (invert_in),
		.fault_sel_in (fault_sel_in),
		.fault_in     (fault_in),
		.pin_out      (pins)
	);

	assign pin_out_first  = pins[0];
	assign pin_out_second = pins[1];

endmodule : pwg_top

// ==== pwg_top_chk.sv ====
`timescale 1ns/1ps

// port-level checks on the pulse generator top
module pwg_top_chk
	import pwg_pkg::*;
#(
	parameter int CW = CNT_W
)
(
	input wire logic            clk_sys_in,
	input wire logic            sys_rst_in,
	input wire logic            run_en_in,
	input wire logic            updown_mode_in,
	input wire logic            sync_upd_in,
	input wire logic [CW-1:0]   period_in,
	input wire logic [CW-1:0]   cmp_a_in,
	input wire logic [CW-1:0]   cmp_b_in,
	input wire logic            db_en_in,
	input wire logic [EV_N-1:0] irq_sel_in,
	input wire logic [1:0]      pin_en_in,
	input wire logic [1:0]      invert_in,
	input wire logic [1:0]      fault_sel_in,
	input wire logic [CW-1:0]   count_out,
	input wire logic            dir_out,
	input wire logic            zero_pulse_out,
	input wire logic            load_pulse_out,
	input wire logic            cmp_a_pulse_out,
	input wire logic            cmp_b_pulse_out,
	input wire logic [EV_N-1:0] event_out,
	input wire logic            irq_out,
	input wire logic            raw_out_first,
	input wire logic            pin_out_first
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	// end-of-range pulses sit on the end values of the count
	AST_ZERO_AT_ZERO:
	assert property (zero_pulse_out |-> count_out == '0)
		else $error("zero pulse away from zero");
	AST_LOAD_AT_TOP:
	assert property (load_pulse_out && !sync_upd_in && $stable(period_in) |-> count_out == period_in)
		else $error("load pulse away from period");
	AST_DOWN_RELOAD:
	assert property (zero_pulse_out && !updown_mode_in && run_en_in ##1 run_en_in |-> load_pulse_out)
		else $error("no load pulse after zero");
	AST_DIR_AT_ENDS:
	assert property (zero_pulse_out || load_pulse_out |-> dir_out == (updown_mode_in && zero_pulse_out))
		else $error("direction wrong at turn");
	// compare A is checked both ways once its inputs have settled
	AST_CMP_A_MATCH:
	assert property (run_en_in && $past(run_en_in, 3) && !$past(sync_upd_in, 3)
		&& cmp_a_in == $past(cmp_a_in, 3) && period_in == $past(period_in, 3)
		|-> cmp_a_pulse_out == (count_out == cmp_a_in && cmp_a_in <= period_in))
		else $error("compare A pulse wrong");
	AST_CMP_B_MATCH:
	assert property (cmp_b_pulse_out && !sync_upd_in |-> count_out == cmp_b_in && cmp_b_in <= period_in)
		else $error("compare B pulse wrong");
	AST_CMP_QUIET:
	assert property (event_out[EV_ZERO] || event_out[EV_LOAD] |-> event_out[EV_B_DOWN:EV_A_UP] == '0)
		else $error("compare event beside zero or load");
	AST_DOWN_FOUR:
	assert property (!updown_mode_in |-> !event_out[EV_A_UP] && !event_out[EV_B_UP])
		else $error("up event in down mode");
	AST_A_TAGGED:
	assert property (event_out[EV_A_UP] || event_out[EV_A_DOWN]
		|-> cmp_a_pulse_out && dir_out == event_out[EV_A_UP])
		else $error("compare A event tagged wrong");
	AST_IRQ_SEL:
	assert property ($stable(irq_sel_in) |-> irq_out == |(event_out & irq_sel_in))
		else $error("interrupt does not follow events");
	// bypass path: pin is raw two cycles late when nothing alters it
	AST_BYPASS_PIN:
	assert property ((!db_en_in && pin_en_in[0] && !fault_sel_in[0] && !invert_in[0])[*3]
		|-> pin_out_first == $past(raw_out_first, 2))
		else $error("bypassed pin differs from raw");

	// main traffic: turnaround, dead-band use, selected interrupt
	COV_UPDN_ZERO: cover property (zero_pulse_out && dir_out);
	COV_DB_RUN: cover property (db_en_in && raw_out_first);
	COV_IRQ: cover property (irq_out);
endmodule : pwg_top_chk

bind pwg_top pwg_top_chk #(.CW(CW)) pwg_top_chk_i (.*);

// ==== tb.sv ====
`timescale 1ns/1ps

// bench: scenarios are call sequences with expected values
module tb;
	import pwg_pkg::*;
	logic              clk_sys_in, sys_rst_in, run_en_in, updown_mode_in, sync_upd_in;
	logic              db_en_in, fault_in, dir_out, irq_out, adc_trig_out, shoot;
	logic [CNT_W-1:0]  period_in, cmp_a_in, cmp_b_in, count_out;
	logic [2*EV_N-1:0] act_first_in, act_second_in;
	logic [DB_W-1:0]   db_rise_in, db_fall_in;
	logic [EV_N-1:0]   irq_sel_in, trig_sel_in, event_out;
	logic [1:0]        pin_en_in, invert_in, fault_sel_in;
	logic              zero_pulse_out, load_pulse_out, cmp_a_pulse_out, cmp_b_pulse_out;
	logic              raw_out_first, raw_out_second, pin_out_first, pin_out_second;
	int                err_count, comparisons, n, i, c;
	wire  [6:0]        obs = {cmp_a_pulse_out, load_pulse_out, zero_pulse_out,
		pin_out_second, pin_out_first, raw_out_second, raw_out_first};

	pwg_top #(.CW(CNT_W), .DW(DB_W)) pwg_top_i (.*);
	pwg_drv_model pwg_drv_model_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.gate_hi_in(pin_out_first), .gate_lo_in(pin_out_second), .shoot_out(shoot));

	initial clk_sys_in = 1'b0;
	always #5 clk_sys_in = ~clk_sys_in;

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// bounded wait on falling edges, so a dead output cannot hang the run
	task wt(input int b, input logic v);
		n = 0;
		while (obs[b] !== v && n < 300)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		if (n == 300)
		begin
			err_count++;
			$display("wrong value at %0t: wait timed out", $time);
		end
	endtask : wt

	// mode is only taken when leaving idle, so reconfigure while stopped
	task start(input logic ud, input logic [15:0] p, input logic [15:0] a, input logic [15:0] b);
		run_en_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		updown_mode_in = ud;
		period_in = p;
		cmp_a_in = a;
		cmp_b_in = b;
		@(negedge clk_sys_in);
		run_en_in = 1'b1;
	endtask : start

	task print_verdict();
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// main sequence
	initial
	begin
		{run_en_in, updown_mode_in, sync_upd_in, db_en_in, fault_in} = '0;
		{period_in, cmp_a_in, cmp_b_in, act_first_in, act_second_in} = '0;
		{db_rise_in, db_fall_in, irq_sel_in, trig_sel_in} = '0;
		{pin_en_in, invert_in, fault_sel_in} = '0;
		err_count = 0;
		comparisons = 0;
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		chk(count_out, 16'h0);
		chk({14'h0, pin_out_second, pin_out_first}, 16'h0);
		// down count, pulses, compare above period, event selection
		irq_sel_in = 6'h01;
		trig_sel_in = 6'h02;
		pin_en_in = 2'h3;
		start(1'b0, 16'h0003, 16'h0002, 16'h0009);
		wt(5, 1'b1);
		for (i = 0; i < 5; i++)
		begin
			chk(count_out, 16'((3 - i) & 3));
			chk({11'h0, dir_out, cmp_a_pulse_out, cmp_b_pulse_out, zero_pulse_out, load_pulse_out},
				{11'h0, 1'b0, i == 1, 1'b0, i == 3, i % 4 == 0});
			chk({14'h0, irq_out, adc_trig_out}, {14'h0, i == 3, i % 4 == 0});
			@(negedge clk_sys_in);
		end
		// triangle count with direction-tagged events, A sitting on the period
		start(1'b1, 16'h0004, 16'h0004, 16'h0002);
		wt(4, 1'b1);
		for (i = 0; i < 9; i++)
		begin
			c = (i <= 4) ? i : 8 - i;
			chk(count_out, 16'(c));
			chk({13'h0, dir_out, zero_pulse_out, load_pulse_out},
				{13'h0, (i % 8) < 4, c == 0, c == 4});
			chk({12'h0, event_out[EV_B_DOWN:EV_A_UP]}, {12'h0, i == 6, i == 2, 2'b00});
			@(negedge clk_sys_in);
		end
		// every action code on the zero event, A and B matching together
		start(1'b0, 16'h0007, 16'h0005, 16'h0005);
		act_second_in = 12'(3 * 64);
		for (c = 0; c < 4; c++)
		begin
			act_first_in = 12'(((c == 3) ? 2 : 3) * 64 + 1024 + c);
			wt(6, 1'b1);
			@(negedge clk_sys_in);
			chk({15'h0, raw_out_first}, 16'(c != 3));
			wt(4, 1'b1);
			@(negedge clk_sys_in);
			chk({14'h0, raw_out_second, raw_out_first}, 16'(c == 0 || c == 3));
		end
		// dead-band pair: delayed rise on first, inverted delayed rise on second
		start(1'b0, 16'h0013, 16'h000a, 16'h000a);
		act_first_in = 12'h0c2;
		db_rise_in = 12'h003;
		db_fall_in = 12'h002;
		db_en_in = 1'b1;
		wt(0, 1'b0);
		wt(0, 1'b1);
		wt(2, 1'b1);
		chk(16'(n), 16'h0005);
		chk({15'h0, pin_out_second}, 16'h0);
		wt(0, 1'b0);
		wt(3, 1'b1);
		chk(16'(n), 16'h0004);
		chk({15'h0, pin_out_first}, 16'h0);
		// output stage: inversion, one pin disabled, then a fault on the first
		db_en_in = 1'b0;
		invert_in = 2'h1;
		pin_en_in = 2'h1;
		wt(0, 1'b1);
		repeat (3) @(negedge clk_sys_in);
		chk({14'h0, pin_out_second, pin_out_first}, 16'h0);
		wt(0, 1'b0);
		repeat (3) @(negedge clk_sys_in);
		chk({14'h0, pin_out_second, pin_out_first}, 16'h1);
		invert_in = 2'h0;
		fault_sel_in = 2'h1;
		wt(0, 1'b1);
		repeat (3) @(negedge clk_sys_in);
		chk({15'h0, pin_out_first}, 16'h1);
		fault_in = 1'b1;
		repeat (6) @(negedge clk_sys_in);
		chk({15'h0, pin_out_first}, 16'h0);
		fault_in = 1'b0;
		fault_sel_in = 2'h0;
		// synced period change waits for the next zero
		start(1'b1, 16'h0007, 16'h0009, 16'h0009);
		sync_upd_in = 1'b1;
		wt(4, 1'b1);
		@(negedge clk_sys_in);
		period_in = 16'h0004;
		wt(5, 1'b1);
		chk(count_out, 16'h0007);
		wt(4, 1'b1);
		wt(5, 1'b1);
		chk(count_out, 16'h0004);
		sync_upd_in = 1'b0;
		chk({15'h0, shoot}, 16'h0);
		print_verdict();
	end

	// the scenarios need well under ten thousand cycles
	initial
	begin
		#100us;
		err_count++;
		print_verdict();
	end
endmodule : tb
